//--- hw/rwa_misc_pins.sv
`timescale 1ns/10ps
module rwa_misc_pins
   import rwa_pkg::*;
#(
   parameter int unsigned RSTGEN_CYC = RSTGEN_HOLD_CYC,
   parameter int unsigned RING_CYC = RING_PULSE_CYC,
   parameter int unsigned LED_CYC = LED_MIN_CYC
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ext_reset_n,
   input wire logic supply_ok,
   input wire logic pll_locked,
   input wire logic crystal_in,
   input wire logic test_mode,
   input wire logic ring_indicator_n,
   input wire rwa_pkg::rwa_usb_status_s usb_status,
   input wire logic uart_tx_busy,
   output logic reset_gen_out_n,
   output logic reset_gen_out_oe,
   output logic tx_activity_led_n,
   output logic tx_activity_led_oe,
   output logic rx_activity_led_n,
   output logic rx_activity_led_oe,
   output logic crystal_out,
   output logic sleep_n,
   output logic power_enable_n,
   output logic rs485_drive_enable,
   output logic remote_wake_req,
   output logic core_reset,
   output logic test_mode_active
);
   import rwa_pkg::*;

   // Pin synchronisers; stage one feeds stage two only
   logic [1:0] ext_rst_sync_r;
   logic [1:0] supply_sync_r;
   logic [1:0] ring_sync_r;
   logic [1:0] xtal_sync_r;
   logic [1:0] test_sync_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ext_rst_sync_r <= 2'h3;
         supply_sync_r <= 2'h0;
         ring_sync_r <= 2'h3;
         xtal_sync_r <= 2'h0;
         test_sync_r <= 2'h0;
      end
      else
      begin
         ext_rst_sync_r <= {ext_rst_sync_r[0], ext_reset_n};
         supply_sync_r <= {supply_sync_r[0], supply_ok};
         ring_sync_r <= {ring_sync_r[0], ring_indicator_n};
         xtal_sync_r <= {xtal_sync_r[0], crystal_in};
         test_sync_r <= {test_sync_r[0], test_mode};
      end
   end

   logic ext_rst_s;
   logic power_good_s;
   assign ext_rst_s = !ext_rst_sync_r[1];
   assign power_good_s = supply_sync_r[1] && pll_locked;

   // Core reset follows the external pin and loss of supply or PLL lock; bus reset is handled elsewhere
   always_ff @(posedge clk)
   begin
      if (srst)
         core_reset <= 1'b1;
      else
         core_reset <= ext_rst_s || !power_good_s;
   end

   // Reset generator
   rwa_rg_state_e rg_state_r;
   logic [CNT_W-1:0] rg_cnt_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rg_state_r <= RWA_RG_WAIT;
         rg_cnt_r <= '0;
      end
      else
      begin
         case (rg_state_r)
            RWA_RG_WAIT:
            begin
               rg_cnt_r <= '0;
               if (power_good_s)
                  rg_state_r <= RWA_RG_HIZ;
            end
            RWA_RG_HIZ:
            begin
               rg_cnt_r <= rg_cnt_r + 1'b1;
               if (!power_good_s)
                  rg_state_r <= RWA_RG_WAIT;
               else if (rg_cnt_r == CNT_W'(RSTGEN_CYC - 1))
                  rg_state_r <= RWA_RG_HIGH;
            end
            RWA_RG_HIGH:
            begin
               if (!power_good_s)
                  rg_state_r <= RWA_RG_WAIT;
            end
            default:
               rg_state_r <= RWA_RG_WAIT;
         endcase
      end
   end

   // Bus reset deliberately absent from this path
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         reset_gen_out_n <= 1'b1;
         reset_gen_out_oe <= 1'b0;
      end
      else if (ext_rst_s)
      begin
         reset_gen_out_n <= 1'b0;
         reset_gen_out_oe <= 1'b1;
      end
      else
      begin
         reset_gen_out_n <= 1'b1;
         reset_gen_out_oe <= (rg_state_r == RWA_RG_HIGH);
      end
   end

   AST_RESET_GEN_OUT_N_LOW: assert property (@(posedge clk) disable iff (srst)
      ext_rst_sync_r[1] == 1'b0 |=> reset_gen_out_oe && !reset_gen_out_n)
      else $error("reset output not driven low");

   AST_RESET_GEN_OUT_N_HIZ: assert property (@(posedge clk) disable iff (srst)
      $rose(rg_state_r == RWA_RG_HIZ) && ext_rst_sync_r[1] |=> !reset_gen_out_oe [*8])
      else $error("reset output driven during hold");

   AST_RESET_GEN_OUT_N_BUSRST: assert property (@(posedge clk) disable iff (srst)
      usb_status.bus_reset && ext_rst_sync_r[1] && rg_state_r == RWA_RG_HIGH
      && $past(rg_state_r) == RWA_RG_HIGH |=> reset_gen_out_oe && reset_gen_out_n)
      else $error("bus reset disturbed reset output");

   // Activity LEDs
   rwa_pin_drive_s tx_led;
   rwa_pin_drive_s rx_led;

   rwa_led_stretch #(.MIN_CYC(CNT_W'(LED_CYC))) u_tx_led (
      .clk(clk),
      .srst(srst),
      .activity(usb_status.tx_active),
      .led_n(tx_led)
   );

   rwa_led_stretch #(.MIN_CYC(CNT_W'(LED_CYC))) u_rx_led (
      .clk(clk),
      .srst(srst),
      .activity(usb_status.rx_active),
      .led_n(rx_led)
   );

   // Extra flop keeps top outputs registered
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tx_activity_led_n <= 1'b1;
         tx_activity_led_oe <= 1'b0;
         rx_activity_led_n <= 1'b1;
         rx_activity_led_oe <= 1'b0;
      end
      else
      begin
         tx_activity_led_n <= tx_led.out;
         tx_activity_led_oe <= tx_led.oe;
         rx_activity_led_n <= rx_led.out;
         rx_activity_led_oe <= rx_led.oe;
      end
   end

   AST_TX_ACTIVITY_LED_N: assert property (@(posedge clk) disable iff (srst)
      usb_status.tx_active |-> ##2 (tx_activity_led_oe && !tx_activity_led_n))
      else $error("tx led not lit");

   AST_RX_ACTIVITY_LED_N: assert property (@(posedge clk) disable iff (srst)
      usb_status.rx_active |-> ##2 (rx_activity_led_oe && !rx_activity_led_n))
      else $error("rx led not lit");

   // Oscillator output: sampled reference, gated in suspend.
   // Limitation: at 25 MHz the 6MHz copy carries sampling jitter.
   always_ff @(posedge clk)
   begin
      if (srst)
         crystal_out <= 1'b0;
      else if (usb_status.suspended)
         crystal_out <= 1'b0;
      else
         crystal_out <= xtal_sync_r[1];
   end

   AST_XTAL_STOP: assert property (@(posedge clk) disable iff (srst)
      usb_status.suspended [*2] |=> $stable(crystal_out) && !crystal_out)
      else $error("oscillator output toggles in suspend");

   // Suspend and power enable
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sleep_n <= 1'b1;
         power_enable_n <= 1'b1;
      end
      else
      begin
         sleep_n <= !usb_status.suspended;
         power_enable_n <= !(usb_status.configured && !usb_status.suspended);
      end
   end

   AST_POWER_ENABLE_N: assert property (@(posedge clk) disable iff (srst)
      usb_status.suspended |=> power_enable_n && !sleep_n)
      else $error("power enable low during suspend");

   // Factory test mode is flagged only; the board keeps it low
   always_ff @(posedge clk)
   begin
      if (srst)
         test_mode_active <= 1'b0;
      else
         test_mode_active <= test_sync_r[1];
   end

   // Ring indicator wake: needs a full 20ms low while suspended
   logic [CNT_W-1:0] ring_cnt_r;
   logic ring_done_r;

   always_ff @(posedge clk)
   begin
      if (srst || ring_sync_r[1] || !usb_status.suspended)
         ring_cnt_r <= '0;
      else if (ring_cnt_r != CNT_W'(RING_CYC))
         ring_cnt_r <= ring_cnt_r + 1'b1;
   end

   // One request per pulse; releasing the pin rearms it
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         remote_wake_req <= 1'b0;
         ring_done_r <= 1'b0;
      end
      else
      begin
         remote_wake_req <= 1'b0;
         if (ring_sync_r[1] || !usb_status.suspended)
            ring_done_r <= 1'b0;
         else if (ring_cnt_r == CNT_W'(RING_CYC) && !ring_done_r)
         begin
            ring_done_r <= 1'b1;
            remote_wake_req <= usb_status.remote_wake_en;
         end
      end
   end

   AST_WAKE_EN: assert property (@(posedge clk) disable iff (srst)
      !usb_status.remote_wake_en |=> !remote_wake_req)
      else $error("wake without enable");

   // RS485 driver enable follows the transmitter
   always_ff @(posedge clk)
   begin
      if (srst)
         rs485_drive_enable <= 1'b0;
      else
         rs485_drive_enable <= uart_tx_busy;
   end

   AST_RS485_DRIVE_ENABLE: assert property (@(posedge clk) disable iff (srst)
      uart_tx_busy |=> rs485_drive_enable)
      else $error("rs485 enable missing");
endmodule

//--- hw/rwa_pkg.sv
package rwa_pkg;

   localparam int unsigned CLK_HZ = 25000000;
   // Reset generator hold time after supply and clock are good
   localparam int unsigned RSTGEN_HOLD_US = 5000;
   localparam int unsigned RSTGEN_HOLD_CYC = (CLK_HZ / 1000000) * RSTGEN_HOLD_US;
   // Ring indicator low pulse needed for a remote wake
   localparam int unsigned RING_PULSE_US = 20000;
   localparam int unsigned RING_PULSE_CYC = (CLK_HZ / 1000000) * RING_PULSE_US;
   // Minimum visible LED pulse
   localparam int unsigned LED_MIN_US = 50000;
   localparam int unsigned LED_MIN_CYC = (CLK_HZ / 1000000) * LED_MIN_US;
   // Reference and working clock
   localparam int unsigned REF_CLK_HZ = 6000000;
   localparam int unsigned PLL_MULT = 8;
   localparam int unsigned WORK_CLK_HZ = REF_CLK_HZ * PLL_MULT;
   localparam int unsigned CNT_W = 24;

   typedef enum logic [1:0] {
      RWA_RG_WAIT,
      RWA_RG_HIZ,
      RWA_RG_HIGH
   } rwa_rg_state_e;

   // Status from the USB engine, same clock
   typedef struct packed {
      logic suspended;
      logic configured;
      logic bus_reset;
      logic tx_active;
      logic rx_active;
      logic remote_wake_en;
   } rwa_usb_status_s;

   // Open-collector / tristate pin pair
   typedef struct packed {
      logic out;
      logic oe;
   } rwa_pin_drive_s;

endpackage

//--- hw/rwa_led_stretch.sv
`timescale 1ns/10ps
module rwa_led_stretch
   import rwa_pkg::*;
#(
   parameter logic [CNT_W-1:0] MIN_CYC = CNT_W'(LED_MIN_CYC)
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic activity,
   output rwa_pkg::rwa_pin_drive_s led_n
);
   logic [CNT_W-1:0] cnt_r;

   // Retrigger restarts the window so steady traffic keeps the LED lit
   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_r <= '0;
      else if (activity)
         cnt_r <= MIN_CYC;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end

   // Open collector: drive low only, release otherwise
   always_ff @(posedge clk)
   begin
      if (srst)
         led_n <= '{out: 1'b1, oe: 1'b0};
      else
         led_n <= (activity || cnt_r > 1) ? rwa_pin_drive_s'{out: 1'b0, oe: 1'b1}
            : rwa_pin_drive_s'{out: 1'b1, oe: 1'b0};
   end

   AST_LED_HOLD: assert property (@(posedge clk) disable iff (srst)
      activity |=> (led_n.oe && !led_n.out) [*8])
      else $error("led released too early");
endmodule

//--- verification/rwa_far_model.sv
`timescale 1ns/10ps
module rwa_far_model
   import rwa_pkg::*;
(
   input wire logic clk,
   output logic ext_reset_n,
   output logic ring_indicator_n,
   output logic crystal_in,
   output logic test_mode,
   output rwa_pkg::rwa_usb_status_s usb_status
);
   initial
   begin
      ext_reset_n = 1'b1;
      ring_indicator_n = 1'b1;
      test_mode = 1'b0;
      crystal_in = 1'b0;
      usb_status = '0;
      // Free running, about 6MHz, unrelated in phase to clk
      forever #83 crystal_in = ~crystal_in;
   end

   // Callers are already at a falling edge of clk
   task automatic set_status(input rwa_usb_status_s s);
      usb_status = s;
   endtask

   task automatic set_reset(input logic v);
      ext_reset_n = v;
   endtask

   task automatic set_test(input logic v);
      test_mode = v;
   endtask

   task automatic ring_pulse(input int n);
      @(negedge clk);
      ring_indicator_n = 1'b0;
      repeat (n) @(negedge clk);
      ring_indicator_n = 1'b1;
   endtask
endmodule

//--- verification/rwa_misc_pins_tb.sv
`timescale 1ns/10ps
module rwa_misc_pins_tb;
   import rwa_pkg::*;
   localparam int RG = 20;
   localparam int RC = 30;
   localparam int LC = 10;
   logic clk, srst, supply_ok, pll_locked, uart_tx_busy;
   logic ext_reset_n, ring_indicator_n, crystal_in, test_mode;
   rwa_usb_status_s usb_status;
   logic reset_gen_out_n, reset_gen_out_oe, tx_activity_led_n, tx_activity_led_oe;
   logic rx_activity_led_n, rx_activity_led_oe, crystal_out, sleep_n, power_enable_n;
   logic rs485_drive_enable, remote_wake_req, core_reset, test_mode_active;
   int miscompares = 0;
   int n_checks = 0;
   int wake_cnt = 0;

   rwa_far_model u_rwa_far_model (.clk(clk), .ext_reset_n(ext_reset_n),
      .ring_indicator_n(ring_indicator_n), .crystal_in(crystal_in),
      .test_mode(test_mode), .usb_status(usb_status));

   rwa_misc_pins #(.RSTGEN_CYC(RG), .RING_CYC(RC), .LED_CYC(LC)) u_rwa_misc_pins (
      .clk(clk), .srst(srst), .ext_reset_n(ext_reset_n), .supply_ok(supply_ok),
      .pll_locked(pll_locked), .crystal_in(crystal_in), .test_mode(test_mode),
      .ring_indicator_n(ring_indicator_n), .usb_status(usb_status),
      .uart_tx_busy(uart_tx_busy), .reset_gen_out_n(reset_gen_out_n),
      .reset_gen_out_oe(reset_gen_out_oe), .tx_activity_led_n(tx_activity_led_n),
      .tx_activity_led_oe(tx_activity_led_oe), .rx_activity_led_n(rx_activity_led_n),
      .rx_activity_led_oe(rx_activity_led_oe), .crystal_out(crystal_out),
      .sleep_n(sleep_n), .power_enable_n(power_enable_n),
      .rs485_drive_enable(rs485_drive_enable), .remote_wake_req(remote_wake_req),
      .core_reset(core_reset), .test_mode_active(test_mode_active));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(negedge clk)
      if (remote_wake_req === 1'b1)
         wake_cnt <= wake_cnt + 1;

   task automatic chk(input logic got, input logic exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic t_rstgen;
      cyc(5);
      chk(reset_gen_out_oe, 1'b0, "reset out driven during hold");
      cyc(RG - 2);
      chk(reset_gen_out_oe, 1'b0, "reset out hold too short");
      cyc(1);
      chk(reset_gen_out_oe, 1'b1, "reset out not driven");
      chk(reset_gen_out_n, 1'b1, "reset out not high");
      chk(core_reset, 1'b0, "core reset without cause");
      u_rwa_far_model.set_status('{bus_reset: 1'b1, default: 1'b0});
      cyc(4);
      chk(reset_gen_out_n & reset_gen_out_oe, 1'b1, "bus reset moved reset out");
      u_rwa_far_model.set_status('0);
   endtask

   task automatic t_ext_reset;
      u_rwa_far_model.set_reset(1'b0);
      cyc(4);
      chk(reset_gen_out_oe, 1'b1, "reset out not driven low");
      chk(reset_gen_out_n, 1'b0, "reset out not low");
      chk(core_reset, 1'b1, "core not reset");
      u_rwa_far_model.set_reset(1'b1);
      cyc(RG + 10);
      chk(reset_gen_out_n, 1'b1, "reset out stuck low");
      chk(core_reset, 1'b0, "core reset stuck");
   endtask

   // Losing supply or clock restarts the hold period
   task automatic t_supply;
      supply_ok = 1'b0;
      cyc(4);
      chk(reset_gen_out_oe, 1'b0, "reset out kept after supply loss");
      chk(core_reset, 1'b1, "core not reset on supply loss");
      supply_ok = 1'b1;
      cyc(RG + 5);
      chk(reset_gen_out_oe & reset_gen_out_n, 1'b1, "reset out not back high");
      pll_locked = 1'b0;
      cyc(2);
      chk(reset_gen_out_oe, 1'b0, "reset out kept without clock");
      chk(core_reset, 1'b1, "core not reset without clock");
      pll_locked = 1'b1;
      cyc(RG + 5);
      chk(reset_gen_out_oe & reset_gen_out_n, 1'b1, "reset out not back high");
      chk(core_reset, 1'b0, "core reset stuck");
   endtask

   task automatic t_led(input logic rx);
      u_rwa_far_model.set_status('{tx_active: !rx, rx_active: rx, default: 1'b0});
      cyc(1);
      u_rwa_far_model.set_status('0);
      cyc(2);
      chk(rx ? rx_activity_led_n : tx_activity_led_n, 1'b0, "led not lit");
      chk(rx ? rx_activity_led_oe : tx_activity_led_oe, 1'b1, "led not driven");
      chk(rx ? tx_activity_led_oe : rx_activity_led_oe, 1'b0, "wrong led lit");
      cyc(LC - 2);
      chk(rx ? rx_activity_led_oe : tx_activity_led_oe, 1'b1, "led pulse short");
      cyc(1);
      chk(rx ? rx_activity_led_oe : tx_activity_led_oe, 1'b0, "led stuck on");
   endtask

   task automatic count_xtal(output int n);
      logic prev;
      n = 0;
      prev = crystal_out;
      repeat (40)
      begin
         @(negedge clk);
         if (crystal_out !== prev)
            n++;
         prev = crystal_out;
      end
   endtask

   task automatic t_power;
      int n;
      u_rwa_far_model.set_status('{configured: 1'b1, default: 1'b0});
      cyc(2);
      chk(power_enable_n, 1'b0, "power not enabled");
      chk(sleep_n, 1'b1, "sleep while awake");
      count_xtal(n);
      chk(n > 5, 1'b1, "oscillator copy idle");
      u_rwa_far_model.set_status('{configured: 1'b1, suspended: 1'b1, default: 1'b0});
      cyc(2);
      chk(sleep_n, 1'b0, "sleep not shown");
      chk(power_enable_n, 1'b1, "power kept in suspend");
      count_xtal(n);
      chk(n == 0 && crystal_out === 1'b0, 1'b1, "oscillator runs in suspend");
   endtask

   task automatic t_wake(input rwa_usb_status_s s, input int len, input int exp);
      int w0;
      u_rwa_far_model.set_status(s);
      w0 = wake_cnt;
      u_rwa_far_model.ring_pulse(len);
      cyc(5);
      chk(wake_cnt - w0 == exp, 1'b1, "wrong wake pulse count");
   endtask

   task automatic t_rs485;
      uart_tx_busy = 1'b1;
      chk(rs485_drive_enable, 1'b0, "driver enabled early");
      cyc(2);
      chk(rs485_drive_enable, 1'b1, "driver not enabled");
      uart_tx_busy = 1'b0;
      cyc(2);
      chk(rs485_drive_enable, 1'b0, "driver stays enabled");
   endtask

   task automatic t_test;
      u_rwa_far_model.set_test(1'b1);
      cyc(4);
      chk(test_mode_active, 1'b1, "test mode not seen");
      u_rwa_far_model.set_test(1'b0);
      cyc(4);
      chk(test_mode_active, 1'b0, "test mode stuck");
   endtask

   // Whole run is well under 1000 cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      $display("MISMATCH %0t watchdog expired", $time);
      give_verdict;
   end

   initial
   begin
      srst = 1'b1;
      supply_ok = 1'b1;
      pll_locked = 1'b1;
      uart_tx_busy = 1'b0;
      cyc(4);
      srst = 1'b0;
      t_rstgen;
      t_ext_reset;
      t_supply;
      t_led(1'b0);
      t_led(1'b1);
      t_power;
      t_wake('{suspended: 1'b1, remote_wake_en: 1'b1, default: 1'b0}, RC + 15, 1);
      t_wake('{suspended: 1'b1, remote_wake_en: 1'b1, default: 1'b0}, RC - 3, 0);
      t_wake('{suspended: 1'b1, default: 1'b0}, RC + 15, 0);
      t_wake('{remote_wake_en: 1'b1, default: 1'b0}, RC + 15, 0);
      t_rs485;
      t_test;
      give_verdict;
   end
endmodule
